// [rxd_pick.sv]
// Function
// - Separate 136-bit descriptor bus, 64-bit payload bus
// - Every received packet gets a descriptor phase
// - Raise offer once first two header dwords valid
// - Offer lasts at least two clock cycles
// - Bits 127:64 first cycle, rest one later
// - Whole descriptor valid in second offer cycle
// - Bits 125:0 carry header, byte 0 highest
// - Bits 127:126 group, 135:128 decode results
// - Endpoint completions carry no decode bits
// - Offer drops cycle after accept, bus freed
// - Reject drops descriptor and releases credits
// - Hold withholds non-posted, offers posted/completion only
// - One descriptor signal set per virtual channel
// - Decode bits: BAR0..5, ROM hit, reserved
// - Non-posted favoured again once hold released
`timescale 1ns/1ns

package rxd_pkg;
	localparam int HDR_W = 128;
	localparam int BUS_W = 136;
	localparam int DEC_W = 8;
	localparam int DEC_LSB = 128;
	localparam int GRP_MSB = 127;
	localparam int GRP_LSB = 126;
	localparam int HI_MSB = 127;
	localparam int HI_LSB = 64;
	localparam int LO_MSB = 63;
	localparam int HDR_MSB = 125;
	localparam int BAR_N = 6;
	localparam int RSV_BIT = 135;
	localparam int NUM_VC_DEF = 4;
	localparam int NUM_VC_MAX = 4;

	typedef enum logic [1:0] {
		RXD_GRP_PST = 2'h0,
		RXD_GRP_NP = 2'h1,
		RXD_GRP_CPL = 2'h2,
		RXD_GRP_RSV = 2'h3
	} rxd_grp_t;

	typedef enum {
		RXD_ST_IDLE,
		RXD_ST_FIRST,
		RXD_ST_WAIT
	} rxd_state_t;

	typedef struct packed {
		logic [HDR_W-1:0] hdr;
		logic rom_hit;
		logic [BAR_N-1:0] bar_hit;
		rxd_grp_t grp;
	} rxd_pkt_t;
endpackage

module rxd_pick #(
	parameter bit IS_ENDPOINT = 1'b1
) (
	input wire logic pc_valid,
	input wire rxd_pkg::rxd_pkt_t pc_pkt,
	input wire logic np_valid,
	input wire rxd_pkg::rxd_pkt_t np_pkt,
	input wire logic np_hold,
	output logic take,
	output logic take_np,
	output logic [rxd_pkg::BUS_W-1:0] desc
);
	rxd_pkg::rxd_pkt_t pkt;
	logic [rxd_pkg::DEC_W-1:0] dec;

	// ----------------------------------------
	// Source choice and descriptor build
	// ----------------------------------------
	always_comb begin
		take_np = np_valid & ~np_hold;
		take = take_np | pc_valid;
		pkt = take_np ? np_pkt : pc_pkt;
		dec = {1'b0, pkt.rom_hit, pkt.bar_hit};
		if (IS_ENDPOINT && pkt.grp == rxd_pkg::RXD_GRP_CPL) begin
			dec = '0;
		end
		desc = {dec, pkt.grp, pkt.hdr[rxd_pkg::HDR_MSB:0]};
	end
endmodule

// [rxd_desc_if.sv]
`timescale 1ns/1ns

module rxd_desc_if #(
	parameter int NUM_VC = rxd_pkg::NUM_VC_DEF,
	parameter bit IS_ENDPOINT = 1'b1
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [NUM_VC-1:0] pc_valid,
	input wire rxd_pkg::rxd_pkt_t pc_pkt [NUM_VC],
	output logic [NUM_VC-1:0] pc_ready,
	input wire logic [NUM_VC-1:0] np_valid,
	input wire rxd_pkg::rxd_pkt_t np_pkt [NUM_VC],
	output logic [NUM_VC-1:0] np_ready,
	output logic [NUM_VC-1:0] pkt_offer,
	output logic [rxd_pkg::BUS_W-1:0] hdr_bus [NUM_VC],
	input wire logic [NUM_VC-1:0] hdr_accept,
	input wire logic [NUM_VC-1:0] hdr_reject,
	input wire logic [NUM_VC-1:0] np_defer,
	input wire logic [NUM_VC-1:0] np_hold,
	output logic [NUM_VC-1:0] data_go,
	output logic [NUM_VC-1:0] credit_rel,
	output rxd_pkg::rxd_grp_t credit_grp [NUM_VC]
);
	// ----------------------------------------
	// One descriptor channel per virtual channel
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < NUM_VC; i++) begin : g_vc
			rxd_pkg::rxd_state_t st_r;
			rxd_pkg::rxd_state_t st_nxt;
			logic offer_r;
			logic offer_nxt;
			logic [rxd_pkg::BUS_W-1:0] bus_r;
			logic [rxd_pkg::BUS_W-1:0] bus_nxt;
			logic [rxd_pkg::BUS_W-1:0] desc_r;
			logic [rxd_pkg::BUS_W-1:0] desc_nxt;
			logic sel_np_r;
			logic sel_np_nxt;
			logic go_r;
			logic go_nxt;
			logic rel_r;
			logic rel_nxt;
			rxd_pkg::rxd_grp_t rgrp_r;
			rxd_pkg::rxd_grp_t rgrp_nxt;
			logic take;
			logic take_np;
			logic [rxd_pkg::BUS_W-1:0] desc;
			logic pop;

			rxd_pick #(
				.IS_ENDPOINT(IS_ENDPOINT)
			) u_pick (
				.pc_valid(pc_valid[i]),
				.pc_pkt(pc_pkt[i]),
				.np_valid(np_valid[i]),
				.np_pkt(np_pkt[i]),
				.np_hold(np_hold[i]),
				.take(take),
				.take_np(take_np),
				.desc(desc)
			);

			// ----------------------------------------
			// Offer sequencing
			// ----------------------------------------
			always_comb begin
				st_nxt = st_r;
				offer_nxt = offer_r;
				bus_nxt = bus_r;
				desc_nxt = desc_r;
				sel_np_nxt = sel_np_r;
				go_nxt = 1'b0;
				rel_nxt = 1'b0;
				rgrp_nxt = rgrp_r;
				pop = 1'b0;
				case (st_r)
					rxd_pkg::RXD_ST_IDLE: begin
						if (take) begin
							st_nxt = rxd_pkg::RXD_ST_FIRST;
							offer_nxt = 1'b1;
							bus_nxt = '0;
							bus_nxt[rxd_pkg::HI_MSB:rxd_pkg::HI_LSB] =
								desc[rxd_pkg::HI_MSB:rxd_pkg::HI_LSB];
							desc_nxt = desc;
							sel_np_nxt = take_np;
						end
					end
					rxd_pkg::RXD_ST_FIRST: begin
						// Responses are not looked at in the first offer cycle
						st_nxt = rxd_pkg::RXD_ST_WAIT;
						bus_nxt = desc_r;
					end
					rxd_pkg::RXD_ST_WAIT: begin
						if (hdr_accept[i]) begin
							st_nxt = rxd_pkg::RXD_ST_IDLE;
							offer_nxt = 1'b0;
							bus_nxt = '0;
							pop = 1'b1;
							go_nxt = 1'b1;
							rel_nxt = 1'b1;
							rgrp_nxt = rxd_pkg::rxd_grp_t'(desc_r[rxd_pkg::GRP_MSB:rxd_pkg::GRP_LSB]);
						end else if (hdr_reject[i]) begin
							st_nxt = rxd_pkg::RXD_ST_IDLE;
							offer_nxt = 1'b0;
							bus_nxt = '0;
							pop = 1'b1;
							rel_nxt = 1'b1;
							rgrp_nxt = rxd_pkg::rxd_grp_t'(desc_r[rxd_pkg::GRP_MSB:rxd_pkg::GRP_LSB]);
						end else if (np_defer[i] && sel_np_r) begin
							// Deferred request stays queued for a later offer
							st_nxt = rxd_pkg::RXD_ST_IDLE;
							offer_nxt = 1'b0;
							bus_nxt = '0;
						end
						// Otherwise everything holds unchanged
					end
					default: begin
						st_nxt = rxd_pkg::RXD_ST_IDLE;
						offer_nxt = 1'b0;
						bus_nxt = '0;
					end
				endcase
			end

			always_ff @(posedge mclk or negedge reset_n) begin
				if (!reset_n) begin
					st_r <= rxd_pkg::RXD_ST_IDLE;
					offer_r <= 1'b0;
					bus_r <= '0;
					desc_r <= '0;
					sel_np_r <= 1'b0;
					go_r <= 1'b0;
					rel_r <= 1'b0;
					rgrp_r <= rxd_pkg::RXD_GRP_PST;
				end else begin
					st_r <= st_nxt;
					offer_r <= offer_nxt;
					bus_r <= bus_nxt;
					desc_r <= desc_nxt;
					sel_np_r <= sel_np_nxt;
					go_r <= go_nxt;
					rel_r <= rel_nxt;
					rgrp_r <= rgrp_nxt;
				end
			end

			assign pkt_offer[i] = offer_r;
			assign hdr_bus[i] = bus_r;
			assign pc_ready[i] = pop & ~sel_np_r;
			assign np_ready[i] = pop & sel_np_r;
			assign data_go[i] = go_r;
			assign credit_rel[i] = rel_r;
			assign credit_grp[i] = rgrp_r;

			// ----------------------------------------
			// Checks
			// ----------------------------------------
			chk_offer_min_two: assert property (
				@(posedge mclk) disable iff (!reset_n)
				$rose(offer_r) |=> offer_r
			) else $error("offer shorter than two cycles");

			chk_upper_first: assert property (
				@(posedge mclk) disable iff (!reset_n)
				(st_r == rxd_pkg::RXD_ST_IDLE && take) |=>
				(bus_r[rxd_pkg::HI_MSB:rxd_pkg::HI_LSB] ==
				$past(desc[rxd_pkg::HI_MSB:rxd_pkg::HI_LSB]))
			) else $error("upper descriptor not valid in first offer cycle");

			chk_full_second: assert property (
				@(posedge mclk) disable iff (!reset_n)
				(st_r == rxd_pkg::RXD_ST_IDLE && take) |=> ##1 (offer_r && bus_r == $past(desc, 2))
			) else $error("descriptor incomplete in second offer cycle");

			chk_drop_after_acc: assert property (
				@(posedge mclk) disable iff (!reset_n)
				(st_r == rxd_pkg::RXD_ST_WAIT && hdr_accept[i]) |=>
				(!offer_r && bus_r == '0 && go_r && rel_r)
			) else $error("offer not dropped after accept");

			chk_reject_frees: assert property (
				@(posedge mclk) disable iff (!reset_n)
				(st_r == rxd_pkg::RXD_ST_WAIT && !hdr_accept[i] && hdr_reject[i]) |->
				(pop ##1 (rel_r && !go_r && !offer_r))
			) else $error("reject did not drop descriptor");

			chk_hold_blocks_np: assert property (
				@(posedge mclk) disable iff (!reset_n)
				(st_r == rxd_pkg::RXD_ST_IDLE && np_hold[i]) |=>
				(!(offer_r && sel_np_r))
			) else $error("non-posted offered during hold");

			chk_np_priority: assert property (
				@(posedge mclk) disable iff (!reset_n)
				(st_r == rxd_pkg::RXD_ST_IDLE && !np_hold[i] && np_valid[i]) |=>
				(offer_r && sel_np_r)
			) else $error("waiting non-posted not favoured");

			chk_stable_wait: assert property (
				@(posedge mclk) disable iff (!reset_n)
				(st_r == rxd_pkg::RXD_ST_WAIT && !hdr_accept[i] && !hdr_reject[i] &&
				!(np_defer[i] && sel_np_r)) |=> ($stable(bus_r) && offer_r)
			) else $error("offer changed without a response");

			chk_cpl_no_decode: assert property (
				@(posedge mclk) disable iff (!reset_n)
				(IS_ENDPOINT && offer_r && st_r == rxd_pkg::RXD_ST_WAIT &&
				bus_r[rxd_pkg::GRP_MSB:rxd_pkg::GRP_LSB] == rxd_pkg::RXD_GRP_CPL) |->
				(bus_r[rxd_pkg::BUS_W-1:rxd_pkg::DEC_LSB] == '0)
			) else $error("endpoint completion carries decode bits");

			chk_rsv_zero: assert property (
				@(posedge mclk) disable iff (!reset_n)
				bus_r[rxd_pkg::RSV_BIT] == 1'b0
			) else $error("reserved decode bit set");

			// ----------------------------------------
			// Response and bookkeeping checks
			// ----------------------------------------
			chk_offer_rise_take: assert property (
				@(posedge mclk) disable iff (!reset_n)
				$rose(offer_r) |-> $past(st_r == rxd_pkg::RXD_ST_IDLE && take)
			) else $error("offer raised without a waiting packet");

			chk_first_lower_zero: assert property (
				@(posedge mclk) disable iff (!reset_n)
				(st_r == rxd_pkg::RXD_ST_FIRST) |->
				(offer_r && bus_r[rxd_pkg::LO_MSB:0] == '0 &&
				bus_r[rxd_pkg::BUS_W-1:rxd_pkg::DEC_LSB] == '0)
			) else $error("lower descriptor bits driven in first offer cycle");

			chk_first_ignores: assert property (
				@(posedge mclk) disable iff (!reset_n)
				(st_r == rxd_pkg::RXD_ST_FIRST) |=> (st_r == rxd_pkg::RXD_ST_WAIT && offer_r)
			) else $error("response taken in first offer cycle");

			chk_wait_full_bus: assert property (
				@(posedge mclk) disable iff (!reset_n)
				(st_r == rxd_pkg::RXD_ST_WAIT) |-> (offer_r && bus_r == desc_r)
			) else $error("descriptor not held while waiting");

			chk_idle_quiet: assert property (
				@(posedge mclk) disable iff (!reset_n)
				(st_r == rxd_pkg::RXD_ST_IDLE) |-> (!offer_r && bus_r == '0)
			) else $error("bus not freed while idle");

			chk_pop_on_resp: assert property (
				@(posedge mclk) disable iff (!reset_n)
				pop |-> (st_r == rxd_pkg::RXD_ST_WAIT && (hdr_accept[i] || hdr_reject[i]))
			) else $error("packet popped without accept or reject");

			chk_defer_no_pop: assert property (
				@(posedge mclk) disable iff (!reset_n)
				(st_r == rxd_pkg::RXD_ST_WAIT && !hdr_accept[i] && !hdr_reject[i] &&
				np_defer[i] && sel_np_r) |->
				(!pop ##1 (!offer_r && !rel_r && !go_r))
			) else $error("deferred request was consumed");

			chk_go_on_accept: assert property (
				@(posedge mclk) disable iff (!reset_n)
				go_r |-> $past(st_r == rxd_pkg::RXD_ST_WAIT && hdr_accept[i])
			) else $error("data phase started without accept");

			chk_rel_on_resp: assert property (
				@(posedge mclk) disable iff (!reset_n)
				rel_r |-> $past(st_r == rxd_pkg::RXD_ST_WAIT && (hdr_accept[i] || hdr_reject[i]))
			) else $error("credits released without a response");

			chk_grp_holds: assert property (
				@(posedge mclk) disable iff (!reset_n)
				!rel_r |-> $stable(rgrp_r)
			) else $error("released group changed without a release");

			chk_source_pick: assert property (
				@(posedge mclk) disable iff (!reset_n)
				(st_r == rxd_pkg::RXD_ST_IDLE && take) |=>
				(sel_np_r == $past(np_valid[i] && !np_hold[i]))
			) else $error("wrong source picked for offer");
		end
	endgenerate
endmodule

// [rxd_app_model.sv]
`timescale 1ns/1ns
// ----------
// Application side
// ----------
module rxd_app_model (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic pkt_offer,
	input wire logic [1:0] mode,
	input wire logic [3:0] dly,
	input wire logic np_ok,
	output logic hdr_accept,
	output logic hdr_reject,
	output logic np_defer,
	output logic np_hold
);
	logic [4:0] cnt_r, cnt_nxt;
	logic fire_r, fire_nxt;
	logic hold_r, hold_nxt;
	always_comb begin
		cnt_nxt = pkt_offer ? cnt_r + 5'h1 : 5'h0;
		fire_nxt = pkt_offer && (cnt_r == {1'b0, dly});
		hold_nxt = (fire_nxt && mode == 2'h2) ? 1'b1 : (np_ok ? 1'b0 : hold_r);
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 5'h0;
			fire_r <= 1'b0;
			hold_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			fire_r <= fire_nxt;
			hold_r <= hold_nxt;
		end
	end
	assign hdr_accept = fire_r && mode == 2'h0;
	assign hdr_reject = fire_r && mode == 2'h1;
	assign np_defer = fire_r && mode == 2'h2;
	assign np_hold = hold_r;
endmodule

// [rxd_desc_if_tb.sv]
`timescale 1ns/1ns
// ----------
// Bench
// ----------
module rxd_desc_if_tb;
	typedef struct packed {
		logic np;
		rxd_pkg::rxd_pkt_t pkt;
		logic [1:0] mode;
		logic [3:0] dly;
		logic np_ok;
		logic go;
		logic rel;
	} rxd_row_t;
	logic mclk;
	logic reset_n;
	logic [0:0] pc_valid, pc_ready, np_valid, np_ready, pkt_offer;
	logic [0:0] hdr_accept, hdr_reject, np_defer, np_hold, data_go, credit_rel;
	rxd_pkg::rxd_pkt_t pc_pkt [1];
	rxd_pkg::rxd_pkt_t np_pkt [1];
	logic [135:0] hdr_bus [1];
	rxd_pkg::rxd_grp_t credit_grp [1];
	logic [1:0] mode;
	logic [3:0] dly;
	logic np_ok;
	int failures = 0;
	int n_tests = 0;
	int cyc = 0;
	int pc_pops = 0;
	int np_pops = 0;
	rxd_row_t rows [6];
	always #50 mclk = ~mclk;
	rxd_desc_if #(.NUM_VC(1)) u_rxd_desc_if (.mclk(mclk), .reset_n(reset_n),
		.pc_valid(pc_valid), .pc_pkt(pc_pkt), .pc_ready(pc_ready), .np_valid(np_valid),
		.np_pkt(np_pkt), .np_ready(np_ready), .pkt_offer(pkt_offer), .hdr_bus(hdr_bus),
		.hdr_accept(hdr_accept), .hdr_reject(hdr_reject), .np_defer(np_defer),
		.np_hold(np_hold), .data_go(data_go), .credit_rel(credit_rel), .credit_grp(credit_grp));
	rxd_app_model u_rxd_app_model (.mclk(mclk), .reset_n(reset_n), .pkt_offer(pkt_offer[0]),
		.mode(mode), .dly(dly), .np_ok(np_ok), .hdr_accept(hdr_accept[0]),
		.hdr_reject(hdr_reject[0]), .np_defer(np_defer[0]), .np_hold(np_hold[0]));
	function automatic logic [135:0] xbus(rxd_pkg::rxd_pkt_t p);
		xbus = {1'b0, p.rom_hit, p.bar_hit, p.grp, p.hdr[125:0]};
		if (p.grp == rxd_pkg::RXD_GRP_CPL)
			xbus[135:128] = 8'h00;
	endfunction
	task automatic chk(string nm, logic [135:0] seen, logic [135:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic run(rxd_row_t r);
		int k;
		logic [135:0] e;
		e = xbus(r.pkt);
		@(posedge mclk);
		mode <= r.mode;
		dly <= r.dly;
		np_ok <= r.np_ok;
		if (r.np) begin
			np_valid <= 1'b1;
			np_pkt[0] <= r.pkt;
		end else begin
			pc_valid <= 1'b1;
			pc_pkt[0] <= r.pkt;
		end
		k = 0;
		@(negedge mclk);
		while (pkt_offer[0] !== 1'b1 && k < 20) begin
			@(negedge mclk);
			k++;
		end
		chk("first", hdr_bus[0], e & {8'h00, {64{1'b1}}, 64'h0});
		@(negedge mclk);
		chk("full", hdr_bus[0], e);
		k = 2;
		@(negedge mclk);
		while (pkt_offer[0] === 1'b1 && k < 20) begin
			@(negedge mclk);
			k++;
		end
		chk("len", 136'(k), 136'(r.dly) + 136'h2);
		chk("free", hdr_bus[0], 136'h0);
		chk("go", data_go[0], r.go);
		chk("rel", credit_rel[0], r.rel);
		if (r.rel)
			chk("grp", credit_grp[0], r.pkt.grp);
	endtask
	always @(posedge mclk) begin
		if (pc_ready[0]) begin
			pc_valid <= 1'b0;
			pc_pops <= pc_pops + 1;
		end
		if (np_ready[0]) begin
			np_valid <= 1'b0;
			np_pops <= np_pops + 1;
		end
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			failures++;
			test_done;
		end
	end
	initial begin
		{mclk, reset_n, pc_valid, np_valid, mode, dly, np_ok} = '0;
		pc_pkt[0] = '0;
		np_pkt[0] = '0;
		rows[0] = '{1'b0, {{4{32'hf1e2d3c4}}, 1'b1, 6'h21, 2'h0}, 2'h0, 4'h0, 1'b1, 1'b1, 1'b1};
		rows[1] = '{1'b0, {{4{32'h0badc0de}}, 1'b1, 6'h3f, 2'h2}, 2'h1, 4'h2, 1'b1, 1'b0, 1'b1};
		rows[2] = '{1'b1, {{4{32'h7e5a0001}}, 1'b0, 6'h01, 2'h1}, 2'h2, 4'h1, 1'b0, 1'b0, 1'b0};
		rows[3] = '{1'b0, {{4{32'h40c38000}}, 1'b0, 6'h10, 2'h0}, 2'h0, 4'h0, 1'b0, 1'b1, 1'b1};
		rows[4] = '{1'b1, {{4{32'h7e5a0001}}, 1'b0, 6'h01, 2'h1}, 2'h0, 4'h3, 1'b1, 1'b1, 1'b1};
		rows[5] = '{1'b0, {{4{32'h4a000002}}, 1'b0, 6'h20, 2'h2}, 2'h0, 4'h7, 1'b1, 1'b1, 1'b1};
		repeat (5) @(posedge mclk);
		chk("rst", hdr_bus[0] | {pkt_offer, data_go, credit_rel, pc_ready}, 136'h0);
		reset_n <= 1'b1;
		foreach (rows[i])
			run(rows[i]);
		chk("pc_pops", pc_pops, 4);
		chk("np_pops", np_pops, 1);
		@(posedge mclk);
		dly <= 4'hf;
		mode <= 2'h0;
		pc_valid <= 1'b1;
		pc_pkt[0] <= rows[0].pkt;
		repeat (3) @(negedge mclk);
		chk("up", pkt_offer[0], 1'b1);
		@(posedge mclk);
		reset_n <= 1'b0;
		pc_valid <= 1'b0;
		@(negedge mclk);
		chk("rst2", hdr_bus[0] | pkt_offer, 136'h0);
		@(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(negedge mclk);
		chk("idle", hdr_bus[0] | pkt_offer, 136'h0);
		test_done;
	end
endmodule
